// ==== dv/spi_host_model.sv ====
// Behavioural serial host: one command byte and one data byte per frame
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// Pacing clock
	input  wire logic clock,
	// Serial pins
	input  wire logic sdo_pin,
	output logic      cs_n_pin,
	output logic      sck_pin,
	output logic      sdi_pin,
	// High while the data byte is on the wire
	output logic      data_phase
);
	// Deselected with the clock standing still
	initial begin
		cs_n_pin = 1'b1;
		sck_pin = 1'b0;
		sdi_pin = 1'b0;
		data_phase = 1'b0;
	end

	// Five cycles a phase, since the device oversamples the pins
	task automatic wait_ph;
		repeat (5) @(negedge clock);
	endtask : wait_ph

	// One frame, polarity chosen while deselected
	task automatic xfer(input logic cpol, input logic [7:0] cmd, dat,
		output logic [7:0] rc, rd);
		logic [15:0] tx;
		logic [15:0] rx;
		tx = {cmd, dat};
		sck_pin = cpol;
		wait_ph();
		cs_n_pin = 1'b0;
		wait_ph();
		for (int i = 0; i < 16; i++) begin
			sck_pin = 1'b0;
			sdi_pin = tx[15-i];
			data_phase = (i >= 8);
			wait_ph();
			rx[15-i] = sdo_pin;
			sck_pin = 1'b1;
			wait_ph();
		end
		sck_pin = cpol;
		wait_ph();
		cs_n_pin = 1'b1;
		data_phase = 1'b0;
		sdi_pin = ~sdi_pin;
		rc = rx[15:8];
		rd = rx[7:0];
	endtask : xfer

	// Clock and data activity while deselected
	task automatic noise;
		for (int i = 0; i < 8; i++) begin
			sck_pin = ~sck_pin;
			sdi_pin = i[0];
			wait_ph();
		end
	endtask : noise
endmodule : spi_host_model
`default_nettype wire

// ==== dv/test_adc_pin_logic.sv ====
// Self-checking bench for the converter pin logic
`timescale 1ns/1ps
`default_nettype none
module test_adc_pin_logic
	import adc_pin_pkg::*;
;
	logic clock, nrst, cs_n_pin, sck_pin, sdi_pin, sdo_o, sdo_oe, sdo_pin, data_phase;
	logic [1:0] chip_addr, irq_mode, clk_sel, prescale_sel, data_format;
	logic [7:0] status_byte, rd_byte, wr_byte, input_select_register;
	logic rd_load, wr_strobe, fast_cmd, scan_mode, por_irq, crc_irq, other_irq;
	logic data_ready, modulator_bit, irq_pin_i, irq_o, irq_oe, irq_line_high;
	logic [3:0] reg_addr, fast_code, scan_pos, scan_neg, vin_pos_sel, vin_neg_sel;
	logic mclk_pin_i, int_osc_i, mclk_o, mclk_oe, ext_mclk, am_prev;
	logic analog_master_clock, digital_master_clock;
	logic [24:0] raw_code;
	logic [31:0] result_code;
	logic sdo_float = 1'b0;
	int failures, checked, n_wr, n_fast, n_ld, oe_hits;
	logic [24:0] corner [4] = '{25'h0800000, 25'h17fffff, 25'h07fffff, 25'h1800000};

	// Clock, 50 ns period
	initial clock = 1'b0;
	always #(CLOCK_NS / 2) clock = ~clock;

	// Pin resolution: released output shows a changing level, interrupt pin pulled up
	assign sdo_pin = sdo_oe ? sdo_o : sdo_float;
	assign irq_pin_i = irq_oe ? irq_o : 1'b1;
	assign mclk_pin_i = mclk_oe ? mclk_o : ext_mclk;

	// Event counters and the float pattern
	always @(posedge clock) begin
		sdo_float <= ~sdo_pin;
		am_prev <= analog_master_clock;
		n_wr <= n_wr + int'(wr_strobe === 1'b1);
		n_fast <= n_fast + int'(fast_cmd === 1'b1);
		n_ld <= n_ld + int'(rd_load === 1'b1);
		oe_hits <= oe_hits + int'(data_phase && sdo_oe === 1'b1);
	end

	// Two unrelated source clocks, both slower than a quarter of the system clock
	always begin
		repeat (4) @(negedge clock);
		ext_mclk = ~ext_mclk;
	end
	always begin
		repeat (6) @(negedge clock);
		int_osc_i = ~int_osc_i;
	end

	adc_pin_logic u_dut (.clock, .nrst, .cs_n_pin, .sck_pin, .sdi_pin, .sdo_o, .sdo_oe,
		.chip_addr, .status_byte, .rd_byte, .rd_load, .reg_addr, .wr_byte, .wr_strobe,
		.fast_cmd, .fast_code, .irq_mode, .clk_sel, .prescale_sel, .data_format,
		.scan_mode, .input_select_register, .scan_pos, .scan_neg, .por_irq, .crc_irq,
		.other_irq, .data_ready, .modulator_bit, .irq_pin_i, .irq_o, .irq_oe,
		.irq_line_high, .mclk_pin_i, .int_osc_i, .mclk_o, .mclk_oe, .analog_master_clock,
		.digital_master_clock, .raw_code, .result_code, .vin_pos_sel, .vin_neg_sel);

	spi_host_model u_host (.clock, .sdo_pin, .cs_n_pin, .sck_pin, .sdi_pin, .data_phase);

	task automatic chk(input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t ns: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic results;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	// Cycles between two analog rises or two digital ticks; second run skips settling
	task automatic period(input logic dm, output int n);
		bit seen;
		for (int r = 0; r < 2; r++) begin
			seen = 0;
			n = 0;
			for (int k = 0; k <= 2000; k++) begin
				if (k == 2000) begin
					failures++;
					results();
				end
				@(negedge clock);
				n++;
				if (dm ? digital_master_clock === 1'b1 : analog_master_clock && !am_prev) begin
					if (seen)
						break;
					seen = 1;
					n = 0;
				end
			end
		end
	endtask : period

	// Saturating or overload code by format
	function automatic logic [31:0] exp_res(input logic [24:0] r, input logic [1:0] f);
		if (f != FMT_SAT)
			return {{7{r[24]}}, r};
		if (r[24] != r[23])
			return r[24] ? SAT_NEG : SAT_POS;
		return {8'h00, r[23:0]};
	endfunction : exp_res

	// One framed transfer and its effects
	task automatic frame(input logic cpol, input logic [1:0] op, input logic match);
		logic [7:0] cmd, dat, rc, rd;
		int w, f;
		cmd = {match ? chip_addr : ~chip_addr, 4'($urandom), op};
		dat = 8'($urandom);
		status_byte = 8'($urandom);
		rd_byte = 8'($urandom);
		w = n_wr;
		f = n_fast;
		oe_hits = 0;
		u_host.xfer(cpol, cmd, dat, rc, rd);
		cyc(4);
		chk(sdo_oe, 1'b0);
		chk(oe_hits != 0, match && op[0]);
		chk(n_wr - w, match && op == OP_WR_INC);
		chk(n_fast - f, match && op == OP_FAST);
		if (match)
			chk(rc, status_byte);
		if (match && op == OP_WR_INC) begin
			chk(wr_byte, dat);
			chk(reg_addr, 4'(cmd[5:2] + 4'h1));
		end
		if (match && op[0])
			chk(rd, rd_byte);
		if (match && op == OP_FAST)
			chk(fast_code, cmd[5:2]);
	endtask : frame

	// Watchdog
	initial begin
		repeat (90000) @(negedge clock);
		failures++;
		results();
	end

	// Main sequence
	initial begin
		int n, lows;
		logic pend;
		void'($urandom(32'h052dc1e0));
		{nrst, chip_addr, irq_mode, clk_sel, prescale_sel, data_format} = '0;
		{status_byte, rd_byte, input_select_register, scan_mode, scan_pos, scan_neg} = '0;
		{por_irq, crc_irq, other_irq, data_ready, modulator_bit, raw_code} = '0;
		{ext_mclk, int_osc_i} = '0;
		chip_addr = 2'($urandom);
		cyc(20);
		chk({sdo_oe, irq_oe, irq_o, mclk_oe}, 4'h2);
		nrst = 1'b1;
		cyc(4);
		u_host.noise();
		cyc(4);
		chk(n_wr + n_fast + n_ld, 0);
		for (int i = 0; i < 16; i++)
			frame(i[0], i[2:1], i != 5 && i != 10);
		// Interrupt pin over every mode and source mix
		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 8; s++) begin
				irq_mode = 2'(m);
				{por_irq, crc_irq, other_irq} = 3'(s);
				modulator_bit = 1'($urandom);
				cyc(24);
				pend = m[1] ? (s[2] | s[1]) : (s != 0);
				if (pend)
					chk({irq_oe, irq_o}, 2'h2);
				else if (m[1])
					chk(irq_o, modulator_bit);
				else
					chk({irq_oe, irq_o}, {m[0], 1'b1});
				chk(irq_line_high, irq_pin_i);
			end
		end
		// Data ready pulse, second request lands inside it
		irq_mode = 2'h1;
		{por_irq, crc_irq, other_irq} = '0;
		cyc(8);
		data_ready = 1'b1;
		lows = 0;
		for (int k = 0; k < 16; k++) begin
			cyc(1);
			data_ready = (k == 2);
			lows += int'(irq_oe === 1'b1 && irq_o === 1'b0);
		end
		chk(lows, DR_PULSE_CYC);
		// Prescaler ratios from the pin source, then the internal source driven out
		for (int p = 0; p < 4; p++) begin
			prescale_sel = 2'(p);
			period(1'b0, n);
			chk(n, 8 << p);
			period(1'b1, n);
			chk(n, 32 << p);
			chk(mclk_oe, 1'b0);
		end
		clk_sel = CLK_SEL_OUT;
		prescale_sel = 2'h1;
		period(1'b0, n);
		chk(n, 24);
		chk({mclk_oe, mclk_o}, {1'b1, analog_master_clock});
		// Result codes and input selectors
		for (int i = 0; i < 20; i++) begin
			raw_code = i < 8 ? corner[i % 4] : 25'($urandom);
			data_format = i < 8 ? 2'(i / 4) : 2'($urandom);
			{scan_mode, scan_pos, scan_neg, input_select_register} = 17'($urandom);
			cyc(2);
			chk(result_code, exp_res(raw_code, data_format));
			chk({vin_pos_sel, vin_neg_sel},
				scan_mode ? {scan_pos, scan_neg} : input_select_register);
		end
		results();
	end
endmodule : test_adc_pin_logic
`default_nettype wire

// ==== hdl/adc_pin_logic.sv ====
// Serial slave framing, interrupt pin and master clock pin of the converter
`timescale 1ns/1ps
`default_nettype none
module adc_pin_logic
	import adc_pin_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// Serial pins
	input  wire logic        cs_n_pin,
	input  wire logic        sck_pin,
	input  wire logic        sdi_pin,
	output logic             sdo_o,
	output logic             sdo_oe,
	// Serial side to register file
	input  wire logic [1:0]  chip_addr,
	input  wire logic [7:0]  status_byte,
	input  wire logic [7:0]  rd_byte,
	output logic             rd_load,
	output logic [3:0]       reg_addr,
	output logic [7:0]       wr_byte,
	output logic             wr_strobe,
	output logic             fast_cmd,
	output logic [3:0]       fast_code,
	// Configuration
	input  wire logic [1:0]  irq_mode,
	input  wire logic [1:0]  clk_sel,
	input  wire logic [1:0]  prescale_sel,
	input  wire logic [1:0]  data_format,
	input  wire logic        scan_mode,
	input  wire logic [7:0]  input_select_register,
	input  wire logic [3:0]  scan_pos,
	input  wire logic [3:0]  scan_neg,
	// Interrupt sources and modulator
	input  wire logic        por_irq,
	input  wire logic        crc_irq,
	input  wire logic        other_irq,
	input  wire logic        data_ready,
	input  wire logic        modulator_bit,
	// Shared interrupt / bitstream pin
	input  wire logic        irq_pin_i,
	output logic             irq_o,
	output logic             irq_oe,
	output logic             irq_line_high,
	// Master clock pin and internal oscillator
	input  wire logic        mclk_pin_i,
	input  wire logic        int_osc_i,
	output logic             mclk_o,
	output logic             mclk_oe,
	output logic             analog_master_clock,
	output logic             digital_master_clock,
	// Conversion result and input selectors
	input  wire logic [24:0] raw_code,
	output logic [31:0]      result_code,
	output logic [3:0]       vin_pos_sel,
	output logic [3:0]       vin_neg_sel
);
	localparam int DRW = $clog2(DR_PULSE_CYC + 1);

	logic [5:0] pins_s;
	spi_st_t    st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] shin_q, shin_d, shout_q, shout_d;
	logic       sdo_q, sdo_d, oe_q, oe_d, seen_q, seen_d;
	logic [3:0] raddr_q, raddr_d, fcode_q, fcode_d;
	logic       incr_q, incr_d;
	logic [7:0] wbyte_q, wbyte_d;
	logic       wstb_q, wstb_d, rld_q, rld_d, fast_q, fast_d;
	logic       sck_d_q, cs_d_q;
	logic [DRW-1:0] dr_cnt_q;
	logic       irq_o_q, irq_oe_q, bitstream_q, mclk_oe_q;
	logic       ana_rise;
	logic [31:0] result_q;
	logic [3:0] vin_pos_q, vin_neg_q;

	// Every pin level, including both clock pins, is synchronised first
	sync2 #(.W(6), .RST(6'h24)) u_sync (
		.clock (clock),
		.nrst  (nrst),
		.d     ({cs_n_pin, sck_pin, sdi_pin, irq_pin_i, mclk_pin_i, int_osc_i}),
		.q     (pins_s)
	);

	// Synchronised pin levels
	wire cs_n_s = pins_s[5];
	wire sck_s  = pins_s[4];
	wire sdi_s  = pins_s[3];
	wire irq_s  = pins_s[2];
	wire mclk_s = pins_s[1];
	wire osc_s  = pins_s[0];

	// Edges; serial clock edges only count while selected
	wire cs_fall  = cs_d_q && !cs_n_s;
	wire sck_rise = sck_s && !sck_d_q && !cs_n_s;
	wire sck_fall = !sck_s && sck_d_q && !cs_n_s;
	wire [7:0] byte_in = {shin_q[6:0], sdi_s};
	wire [1:0] addr_in = {shin_q[0], sdi_s};
	wire [1:0] op_in   = byte_in[CMD_OP_HI:CMD_OP_LO];

	// Edge detect history
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sck_d_q <= 1'b0;
			cs_d_q  <= 1'b1;
		end else begin
			sck_d_q <= sck_s;
			cs_d_q  <= cs_n_s;
		end
	end

	// Transaction sequencer; a fall before any rise is skipped, so an
	// idle-high clock at selection does not shift out early
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		shin_d  = shin_q;
		shout_d = shout_q;
		sdo_d   = sdo_q;
		oe_d    = oe_q;
		seen_d  = seen_q;
		raddr_d = raddr_q;
		fcode_d = fcode_q;
		incr_d  = incr_q;
		wbyte_d = wbyte_q;
		wstb_d  = 1'b0;
		rld_d   = 1'b0;
		fast_d  = 1'b0;
		if (cs_n_s) begin
			st_d   = ST_IDLE;
			cnt_d  = 3'h0;
			oe_d   = 1'b0;
			seen_d = 1'b0;
		end else if (cs_fall) begin
			st_d    = ST_CMD;
			cnt_d   = 3'h0;
			seen_d  = 1'b0;
			sdo_d   = status_byte[7];
			shout_d = {status_byte[6:0], 1'b0};
			oe_d    = 1'b1;
		end else begin
			if (sck_rise) begin
				cnt_d  = cnt_q + 3'h1;
				seen_d = 1'b1;
				if (st_q != ST_RD) begin
					shin_d = byte_in;
				end
				case (st_q)
					ST_CMD: begin
						if (cnt_q == 3'h1 && addr_in != chip_addr) begin
							st_d = ST_QUIET;
							oe_d = 1'b0;
						end else if (cnt_q == 3'h7) begin
							raddr_d = byte_in[CMD_REG_HI:CMD_REG_LO];
							incr_d  = (op_in == OP_RD_INC) || (op_in == OP_WR_INC);
							case (op_in)
								OP_FAST: begin
									st_d    = ST_QUIET;
									oe_d    = 1'b0;
									fast_d  = 1'b1;
									fcode_d = byte_in[CMD_REG_HI:CMD_REG_LO];
								end
								OP_WR_INC: begin
									st_d = ST_WR;
									oe_d = 1'b0;
								end
								default: begin
									st_d  = ST_RD;
									rld_d = 1'b1;
								end
							endcase
						end
					end
					ST_WR: begin
						if (cnt_q == 3'h7) begin
							wbyte_d = byte_in;
							wstb_d  = 1'b1;
							raddr_d = raddr_q + 4'h1;
						end
					end
					ST_RD: begin
						if (cnt_q == 3'h7) begin
							rld_d   = 1'b1;
							raddr_d = incr_q ? raddr_q + 4'h1 : raddr_q;
						end
					end
					default: begin
					end
				endcase
			end
			if (sck_fall && seen_q) begin
				seen_d = 1'b0;
				if (st_q == ST_RD && cnt_q == 3'h0) begin
					sdo_d   = rd_byte[7];
					shout_d = {rd_byte[6:0], 1'b0};
				end else begin
					sdo_d   = shout_q[7];
					shout_d = {shout_q[6:0], 1'b0};
				end
			end
		end
	end

	// Serial state registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_q    <= ST_IDLE;
			cnt_q   <= 3'h0;
			shin_q  <= 8'h00;
			shout_q <= 8'h00;
			sdo_q   <= 1'b0;
			oe_q    <= 1'b0;
			seen_q  <= 1'b0;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			shin_q  <= shin_d;
			shout_q <= shout_d;
			sdo_q   <= sdo_d;
			oe_q    <= oe_d;
			seen_q  <= seen_d;
		end
	end

	// Register side outputs
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			raddr_q <= 4'h0;
			fcode_q <= 4'h0;
			incr_q  <= 1'b0;
			wbyte_q <= 8'h00;
			wstb_q  <= 1'b0;
			rld_q   <= 1'b0;
			fast_q  <= 1'b0;
		end else begin
			raddr_q <= raddr_d;
			fcode_q <= fcode_d;
			incr_q  <= incr_d;
			wbyte_q <= wbyte_d;
			wstb_q  <= wstb_d;
			rld_q   <= rld_d;
			fast_q  <= fast_d;
		end
	end

	assign sdo_o     = sdo_q;
	assign sdo_oe    = oe_q;
	assign reg_addr  = raddr_q;
	assign wr_byte   = wbyte_q;
	assign wr_strobe = wstb_q;
	assign rd_load   = rld_q;
	assign fast_cmd  = fast_q;
	assign fast_code = fcode_q;

	// Master clock source and prescaler
	wire clk_src = clk_sel[CLK_SEL_INT_BIT] ? osc_s : mclk_s;
	mclk_divider u_div (
		.clock        (clock),
		.nrst         (nrst),
		.src          (clk_src),
		.prescale_sel (prescale_sel),
		.ana_clk_q    (analog_master_clock),
		.ana_rise     (ana_rise),
		.dig_tick_q   (digital_master_clock)
	);

	// Pin drives out only when the internal clock is selected for output
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mclk_oe_q <= 1'b0;
		end else begin
			mclk_oe_q <= (clk_sel == CLK_SEL_OUT);
		end
	end
	assign mclk_o  = analog_master_clock;
	assign mclk_oe = mclk_oe_q;

	// Interrupt pin decode
	wire lvl_pend  = por_irq || crc_irq;
	wire dr_active = (dr_cnt_q != '0);
	wire pend_all  = lvl_pend || other_irq || dr_active;
	wire bits_mode = irq_mode[IRQ_SEL_BIT];
	wire inact_hi  = irq_mode[IRQ_INACT_BIT];
	wire irq_o_d   = bits_mode ? (!lvl_pend && bitstream_q) : !pend_all;
	wire irq_oe_d  = bits_mode || pend_all || inact_hi;

	// A pulse starts only when the line reads back high, else the host
	// could not see the falling edge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dr_cnt_q <= '0;
		end else if (data_ready && irq_s && !dr_active && !bits_mode) begin
			dr_cnt_q <= DRW'(DR_PULSE_CYC);
		end else if (dr_active) begin
			dr_cnt_q <= dr_cnt_q - DRW'(1);
		end
	end

	// Pin registers and modulator bit capture on analog clock rise
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq_o_q  <= 1'b1;
			irq_oe_q <= 1'b0;
			bitstream_q <= 1'b0;
		end else begin
			irq_o_q  <= irq_o_d;
			irq_oe_q <= irq_oe_d;
			bitstream_q <= ana_rise ? modulator_bit : bitstream_q;
		end
	end
	assign irq_o         = irq_o_q;
	assign irq_oe        = irq_oe_q;
	assign irq_line_high = irq_s;

	// Out of range detection on the wide result
	wire sat_hi = !raw_code[24] && raw_code[23];
	wire sat_lo = raw_code[24] && !raw_code[23];
	wire [31:0] sat_word = sat_hi ? SAT_POS : (sat_lo ? SAT_NEG : {8'h00, raw_code[23:0]});
	wire [31:0] ovl_word = {{7{raw_code[24]}}, raw_code};

	// Result word and input selectors
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			result_q  <= 32'h00000000;
			vin_pos_q <= 4'h0;
			vin_neg_q <= 4'h0;
		end else begin
			result_q  <= (data_format == FMT_SAT) ? sat_word : ovl_word;
			vin_pos_q <= scan_mode ? scan_pos : input_select_register[7:4];
			vin_neg_q <= scan_mode ? scan_neg : input_select_register[3:0];
		end
	end
	assign result_code = result_q;
	assign vin_pos_sel = vin_pos_q;
	assign vin_neg_sel = vin_neg_q;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	a_cs_tristate: assert property (cs_n_s |=> !sdo_oe)
		else $error("output driven while deselected");
	a_idle_ignored: assert property (cs_n_s |=> st_q == ST_IDLE && !wr_strobe && !fast_cmd)
		else $error("activity while deselected");
	a_quiet_tristate: assert property ((st_q == ST_QUIET || st_q == ST_WR) |-> !sdo_oe)
		else $error("output driven after write or fast command");
	a_addr_mismatch: assert property ((st_q == ST_CMD && sck_rise && !cs_fall && cnt_q == 3'h1
		&& addr_in != chip_addr) |=> st_q == ST_QUIET && !sdo_oe)
		else $error("address mismatch not tristated");
	a_read_sdi_ignored: assert property ((st_q == ST_RD && sck_rise) |=> $stable(shin_q))
		else $error("input shifted during read");
	a_sample_rise: assert property ((st_q == ST_CMD && sck_rise && !cs_fall)
		|=> shin_q[0] == $past(sdi_s))
		else $error("input not sampled on rise");
	a_irq_level_low: assert property (lvl_pend |=> irq_oe && !irq_o)
		else $error("level interrupt not driving pin low");
	a_irq_inactive: assert property ((!bits_mode && !pend_all)
		|=> irq_o && irq_oe == $past(inact_hi))
		else $error("wrong inactive level");
	a_bitstream_out: assert property ((bits_mode && !lvl_pend) |=> irq_o == $past(bitstream_q))
		else $error("bitstream not on pin");
	a_dr_pulse: assert property ($rose(dr_active) |-> dr_active [*4] ##1 !dr_active)
		else $error("data ready pulse width wrong");
	a_mclk_out: assert property ((clk_sel == CLK_SEL_OUT) |=> mclk_oe)
		else $error("clock pin not driven");
	a_saturate: assert property ((data_format == FMT_SAT && sat_hi) |=> result_code == SAT_POS)
		else $error("no positive saturation");

	c_read: cover property (st_q == ST_RD && rd_load);
	c_write: cover property (wr_strobe);
	c_fast: cover property (fast_cmd);
	c_bits_irq: cover property (bits_mode && lvl_pend ##1 !irq_o);
endmodule : adc_pin_logic
`default_nettype wire

// ==== hdl/adc_pin_pkg.sv ====
// Constants and types shared by the converter pin logic
package adc_pin_pkg;
	// System clock
	localparam int CLOCK_NS = 50;
	// Command byte fields
	localparam int CMD_ADDR_HI = 7;
	localparam int CMD_ADDR_LO = 6;
	localparam int CMD_REG_HI  = 5;
	localparam int CMD_REG_LO  = 2;
	localparam int CMD_OP_HI   = 1;
	localparam int CMD_OP_LO   = 0;
	// Command types
	localparam logic [1:0] OP_FAST    = 2'h0;
	localparam logic [1:0] OP_RD_STAT = 2'h1;
	localparam logic [1:0] OP_WR_INC  = 2'h2;
	localparam logic [1:0] OP_RD_INC  = 2'h3;
	// Interrupt pin configuration field
	localparam int IRQ_SEL_BIT   = 1;
	localparam int IRQ_INACT_BIT = 0;
	// Clock source select: internal oscillator with clock driven out
	localparam int         CLK_SEL_INT_BIT = 1;
	localparam logic [1:0] CLK_SEL_OUT     = 2'h3;
	// Digital master clock is the analog master clock over four
	localparam logic [1:0] DIG_DIV_M1 = 2'h3;
	// Data ready pulse width
	localparam int DR_PULSE_NS  = 200;
	localparam int DR_PULSE_CYC = (DR_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
	// Output word format and saturation codes
	localparam logic [1:0]  FMT_SAT = 2'h0;
	localparam logic [31:0] SAT_POS = 32'h007fffff;
	localparam logic [31:0] SAT_NEG = 32'h00800000;
	// Serial transaction states
	typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_WR, ST_RD, ST_QUIET} spi_st_t;
endpackage : adc_pin_pkg

// ==== hdl/mclk_divider.sv ====
// Prescaler from master clock level to analog and digital master clocks
`timescale 1ns/1ps
`default_nettype none
module mclk_divider
	import adc_pin_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       nrst,
	// Synchronised master clock level and ratio select
	input  wire logic       src,
	input  wire logic [1:0] prescale_sel,
	// Divided clocks
	output logic            ana_clk_q,
	output logic            ana_rise,
	output logic            dig_tick_q
);
	logic       src_d_q;
	logic [2:0] edge_cnt_q;
	logic [2:0] edge_cnt_d;
	logic [1:0] ana_cnt_q;

	// Ratio is 1, 2, 4 or 8; edges counted on both phases
	wire       src_edge  = src ^ src_d_q;
	wire [2:0] edges_m1  = 3'((4'h1 << prescale_sel) - 4'h1);
	wire       toggle    = src_edge && (edge_cnt_q == edges_m1);
	assign edge_cnt_d = toggle ? 3'h0 : (src_edge ? edge_cnt_q + 3'h1 : edge_cnt_q);
	assign ana_rise = toggle && !ana_clk_q;

	// Analog master clock is the master clock over the ratio
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			src_d_q    <= 1'b0;
			edge_cnt_q <= 3'h0;
			ana_clk_q  <= 1'b0;
		end else begin
			src_d_q    <= src;
			edge_cnt_q <= edge_cnt_d;
			ana_clk_q  <= toggle ? !ana_clk_q : ana_clk_q;
		end
	end

	// One sample tick for every fourth analog clock rise
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ana_cnt_q  <= 2'h0;
			dig_tick_q <= 1'b0;
		end else begin
			ana_cnt_q  <= ana_rise ? ana_cnt_q + 2'h1 : ana_cnt_q;
			dig_tick_q <= ana_rise && (ana_cnt_q == DIG_DIV_M1);
		end
	end
endmodule : mclk_divider
`default_nettype wire

// ==== hdl/sync2.sv ====
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         nrst,
	// Levels in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	// First stage is read only by the second; reset to the pins' idle levels
	// so that no false edge follows reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_q <= RST;
			q      <= RST;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : sync2
`default_nettype wire
